// *** hw/swd_nv_timer.sv ***
// Nonvolatile write cycle timer: busy from start for CYCLES clocks.
// Assumes start is a one-cycle pulse, ignored while busy.
`include "swd_params.svh"
module swd_nv_timer
   import swd_pkg::*;
#(
   parameter int CYCLES = `SWD_NV_WRITE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   output logic busy,
   output logic done
);

   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_r;

   // ------------------------------------------------------------
   // Count
   // ------------------------------------------------------------
   // (RQ21) bounded write time
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            cnt_r <= CW'(CYCLES - 1);
         end else if (busy) begin
            if (cnt_r == '0) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 1'b1;
            end
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_busy_bound: assert property (busy |-> cnt_r < CW'(CYCLES)) // (RQ21)
      else $error("write cycle counter out of range");
   chk_busy_start: assert property (!busy && start |=> busy && cnt_r == CW'(CYCLES - 1)) // (RQ9)
      else $error("write cycle did not start");

endmodule // swd_nv_timer

// *** hw/swd_params.svh ***
// Constants of the serial wiper command decoder: opcodes, field positions,
// reset values and timing counts. Assumes a 25 MHz core clock.
`ifndef SWD_PARAMS_SVH
`define SWD_PARAMS_SVH

// ------------------------------------------------------------
// Frame fields
// ------------------------------------------------------------
`define SWD_ID_FIXED_BITS 3'h6
`define SWD_STATUS_LOW 2'h1
`define SWD_DATA_MSB 5

// ------------------------------------------------------------
// Opcodes
// ------------------------------------------------------------
`define SWD_OP_RD_WIPER 4'h9
`define SWD_OP_WR_WIPER 4'ha
`define SWD_OP_RD_SET 4'hb
`define SWD_OP_WR_SET 4'hc
`define SWD_OP_SET_TO_WIPER 4'hd
`define SWD_OP_WIPER_TO_SET 4'he
`define SWD_OP_INCDEC 4'h2
`define SWD_OP_STATUS 4'h5

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define SWD_WIPER_RST 6'h00
`define SWD_SETTING_RST 6'h00
`define SWD_WIPER_MAX 6'h3f
`define SWD_WIPER_MIN 6'h00
`define SWD_PIN_RST 5'h19

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SWD_CLK_MHZ 25
`define SWD_NV_WRITE_US 10000
`define SWD_NV_WRITE_CYC (`SWD_NV_WRITE_US * `SWD_CLK_MHZ)
`define SWD_SETTLE_NS 400
`define SWD_SETTLE_CYC ((`SWD_SETTLE_NS * `SWD_CLK_MHZ + 999) / 1000)

`endif

// *** hw/swd_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes pins are quasi-static against the core clock (link clock 320 ns).
module swd_pin_sync
   import swd_pkg::*;
#(
   parameter int W = 5,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_lvl
);

   // ------------------------------------------------------------
   // Per-bit chain
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               s1_r <= RST_VAL[i];
               s2_r <= RST_VAL[i];
               s3_r <= RST_VAL[i];
               pin_lvl[i] <= RST_VAL[i];
            end else begin
               s1_r <= pin_in[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               // Only a level seen by both late stages counts
               if (s2_r == s3_r) begin
                  pin_lvl[i] <= s3_r;
               end
            end
         end
      end
   endgenerate

endmodule // swd_pin_sync

// *** hw/swd_pkg.sv ***
// Types shared by the serial wiper command decoder.
// Assumes swd_params.svh is on the include path.
package swd_pkg;

   // ------------------------------------------------------------
   // Frame sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SWD_IDLE = 3'b000,
      SWD_ID = 3'b001,
      SWD_INSTR = 3'b010,
      SWD_DATA = 3'b011,
      SWD_INCDEC = 3'b100,
      SWD_IGNORE = 3'b101
   } swd_state_t;

   // ------------------------------------------------------------
   // Pin group as seen after synchronising
   // ------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic address_select_pin;
      logic wp_n;
   } swd_pins_t;

endpackage

// *** hw/swd_top.sv ***
// Serial command decoder of one digital potentiometer: frame sequencing,
// wiper position register, four stored settings and their write cycles.
// Assumes all pins are asynchronous to core_clk and sck runs well below it.
//
// What this block does
// (RQ1) After select falls, first byte is identification; its upper nibble checks the type.
// (RQ2) Identification lowest bit must equal the address select pin to continue.
// (RQ3) Host sets identification bits three to one to binary 110.
// (RQ4) Second byte: opcode nibble, two pointer bits, two low bits zero except status.
// (RQ5) Eight opcodes decoded: reads, writes, two transfers, step mode, status.
// (RQ6) Pointer picks one of four settings for setting and transfer commands.
// (RQ7) Transfers end after the instruction byte; host then raises select.
// (RQ8) Setting-to-wiper copies setting into wiper; output follows after settle delay.
// (RQ9) Wiper-to-setting stores wiper into setting as a timed nonvolatile write.
// (RQ10) Reads, writes and status run as three bytes.
// (RQ11) Wiper read returns two zeros then six wiper bits, MSB first.
// (RQ12) Wiper write loads the low six bits of the third byte.
// (RQ13) Setting read returns two zeros then the selected six-bit setting.
// (RQ14) Setting write saves the six data bits into the pointed setting.
// (RQ15) Status returns seven zeros then the busy flag in bit zero.
// (RQ16) Step mode: each clock with input high moves wiper up one.
// (RQ17) Step mode: each clock with input low moves wiper down one.
// (RQ18) Input sampled on rising serial clock; output changes on falling edge.
// (RQ19) Save starts only at select rise after a complete write; busy meanwhile.
// (RQ20) Write protect low blocks setting saves, not wiper updates.
// (RQ21) A setting save completes within ten milliseconds.
// (RQ22) Step clamps at 0 and 63; mismatched identification ignores the frame.
`include "swd_params.svh"
module swd_top
   import swd_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE = 4'ha, // Arbitrary type code
   parameter int NV_WRITE_CYCLES = `SWD_NV_WRITE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic si_pin,
   input wire logic address_select_pin,
   input wire logic wp_n_pin,
   output logic so_out,
   output logic so_oe_n,
   output logic [5:0] wiper_bits,
   output logic nv_write_busy
);

   // ------------------------------------------------------------
   // Pin synchronisers and edges
   // ------------------------------------------------------------
   swd_pins_t pins_in;
   swd_pins_t p;
   swd_pins_t prev_r;

   assign pins_in = '{cs_n: cs_n_pin, sck: sck_pin, si: si_pin,
                      address_select_pin: address_select_pin, wp_n: wp_n_pin};

   swd_pin_sync #(.W(5), .RST_VAL(`SWD_PIN_RST)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pin_in(pins_in),
      .pin_lvl(p)
   );

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev_r <= swd_pins_t'(`SWD_PIN_RST);
      end else begin
         prev_r <= p;
      end
   end

   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   assign cs_fall = prev_r.cs_n && !p.cs_n;
   assign cs_rise = !prev_r.cs_n && p.cs_n;
   // (RQ18) sample on rising, drive on falling
   assign sck_rise = !prev_r.sck && p.sck && !p.cs_n;
   assign sck_fall = prev_r.sck && !p.sck && !p.cs_n;

   // ------------------------------------------------------------
   // Bit framing
   // ------------------------------------------------------------
   swd_state_t state_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] rx_r;
   logic [7:0] rx_nxt;
   logic byte_done;
   logic [3:0] op_r;
   logic [1:0] ptr_r;
   logic [3:0] op_nxt;
   logic [1:0] ptr_nxt;
   logic id_ok;
   logic instr_done;
   logic data_done;

   assign rx_nxt = {rx_r[6:0], p.si};
   assign byte_done = sck_rise && bit_cnt_r == 3'h7;
   // (RQ4) opcode nibble and pointer
   assign op_nxt = rx_nxt[7:4];
   assign ptr_nxt = rx_nxt[3:2];
   // (RQ1) type check (RQ2) address bit
   assign id_ok = rx_nxt[7:4] == DEV_TYPE && rx_nxt[0] == p.address_select_pin;
   assign instr_done = byte_done && state_r == SWD_INSTR;
   assign data_done = byte_done && state_r == SWD_DATA;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bit_cnt_r <= 3'h0;
         rx_r <= 8'h00;
      end else if (cs_fall) begin
         bit_cnt_r <= 3'h0;
         rx_r <= 8'h00;
      end else if (sck_rise) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         rx_r <= rx_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         op_r <= 4'h0;
         ptr_r <= 2'h0;
      end else if (instr_done) begin
         op_r <= op_nxt;
         ptr_r <= ptr_nxt;
      end
   end

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= SWD_IDLE;
      end else if (cs_rise) begin
         state_r <= SWD_IDLE;
      end else if (cs_fall) begin
         state_r <= SWD_ID;
      end else if (byte_done) begin
         unique case (state_r)
            SWD_IDLE, SWD_INCDEC, SWD_IGNORE: begin
               state_r <= state_r;
            end
            // (RQ22) foreign identification: sit out the frame
            SWD_ID: begin
               state_r <= id_ok ? SWD_INSTR : SWD_IGNORE;
            end
            // (RQ5) opcode decode (RQ7) transfers end here (RQ10) three bytes
            SWD_INSTR: begin
               unique case (op_nxt)
                  `SWD_OP_INCDEC: state_r <= SWD_INCDEC;
                  `SWD_OP_RD_WIPER, `SWD_OP_WR_WIPER, `SWD_OP_RD_SET,
                  `SWD_OP_WR_SET, `SWD_OP_STATUS: state_r <= SWD_DATA;
                  default: state_r <= SWD_IGNORE;
               endcase
            end
            SWD_DATA: begin
               state_r <= SWD_IGNORE;
            end
            default: begin
               state_r <= SWD_IGNORE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Wiper position register
   // ------------------------------------------------------------
   logic [5:0] wiper_position_reg_r;
   logic [5:0] stored_setting_reg_r [4];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wiper_position_reg_r <= `SWD_WIPER_RST;
      end else if (instr_done && op_nxt == `SWD_OP_SET_TO_WIPER) begin
         // (RQ6) pointer picks setting (RQ8) copy into wiper
         wiper_position_reg_r <= stored_setting_reg_r[ptr_nxt];
      end else if (data_done && op_r == `SWD_OP_WR_WIPER) begin
         // (RQ12) load six data bits, not gated by write protect
         wiper_position_reg_r <= rx_nxt[`SWD_DATA_MSB:0];
      end else if (state_r == SWD_INCDEC && sck_rise) begin
         // (RQ16) step up (RQ17) step down (RQ22) clamp at ends
         if (p.si && wiper_position_reg_r != `SWD_WIPER_MAX) begin
            wiper_position_reg_r <= wiper_position_reg_r + 6'h01;
         end else if (!p.si && wiper_position_reg_r != `SWD_WIPER_MIN) begin
            wiper_position_reg_r <= wiper_position_reg_r - 6'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Wiper settle delay
   // ------------------------------------------------------------
   // The tap switches are not make-before-break, so the output only
   // follows once the register has been stable for the settle time.
   logic [5:0] wiper_seen_r;
   logic [7:0] settle_cnt_r;

   // (RQ8) output follows after settle delay
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wiper_seen_r <= `SWD_WIPER_RST;
         settle_cnt_r <= 8'h00;
         wiper_bits <= `SWD_WIPER_RST;
      end else begin
         wiper_seen_r <= wiper_position_reg_r;
         if (wiper_position_reg_r != wiper_seen_r) begin
            settle_cnt_r <= 8'h00;
         end else if (wiper_bits != wiper_seen_r) begin
            if (settle_cnt_r == 8'(`SWD_SETTLE_CYC - 1)) begin
               wiper_bits <= wiper_seen_r;
               settle_cnt_r <= 8'h00;
            end else begin
               settle_cnt_r <= settle_cnt_r + 8'h01;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Stored settings and their write cycle
   // ------------------------------------------------------------
   logic frame_ok_r;
   logic [5:0] pend_data_r;
   logic [1:0] pend_idx_r;
   logic [5:0] wr_data_r;
   logic [1:0] wr_idx_r;
   logic nv_start;
   logic nv_done;

   // (RQ19) start only at select rise after a complete write (RQ20) protect
   assign nv_start = cs_rise && frame_ok_r && p.wp_n && !nv_write_busy;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         frame_ok_r <= 1'b0;
         pend_data_r <= 6'h00;
         pend_idx_r <= 2'h0;
      end else if (cs_fall || cs_rise) begin
         frame_ok_r <= 1'b0;
      end else if (instr_done && op_nxt == `SWD_OP_WIPER_TO_SET) begin
         // (RQ9) capture current wiper for the save
         frame_ok_r <= 1'b1;
         pend_data_r <= wiper_position_reg_r;
         pend_idx_r <= ptr_nxt;
      end else if (data_done && op_r == `SWD_OP_WR_SET) begin
         // (RQ14) capture new value for pointed setting
         frame_ok_r <= 1'b1;
         pend_data_r <= rx_nxt[`SWD_DATA_MSB:0];
         pend_idx_r <= ptr_r;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_data_r <= 6'h00;
         wr_idx_r <= 2'h0;
      end else if (nv_start) begin
         wr_data_r <= pend_data_r;
         wr_idx_r <= pend_idx_r;
      end
   end

   swd_nv_timer #(.CYCLES(NV_WRITE_CYCLES)) u_nv (
      .core_clk(core_clk),
      .rst(rst),
      .start(nv_start),
      .busy(nv_write_busy),
      .done(nv_done)
   );

   // Cell takes the new value at the end of the write cycle
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_set
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               stored_setting_reg_r[gi] <= `SWD_SETTING_RST;
            end else if (nv_done && wr_idx_r == 2'(gi)) begin
               stored_setting_reg_r[gi] <= wr_data_r;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Serial output
   // ------------------------------------------------------------
   logic [7:0] tx_r;
   logic rd_op_r;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_r <= 8'h00;
         rd_op_r <= 1'b0;
      end else if (instr_done) begin
         rd_op_r <= 1'b0;
         tx_r <= 8'h00;
         unique case (op_nxt)
            // (RQ11) wiper read byte
            `SWD_OP_RD_WIPER: begin
               rd_op_r <= 1'b1;
               tx_r <= {2'b00, wiper_position_reg_r};
            end
            // (RQ13) setting read byte
            `SWD_OP_RD_SET: begin
               rd_op_r <= 1'b1;
               tx_r <= {2'b00, stored_setting_reg_r[ptr_nxt]};
            end
            // (RQ15) status byte
            `SWD_OP_STATUS: begin
               rd_op_r <= rx_nxt[1:0] == `SWD_STATUS_LOW;
               tx_r <= {7'h00, nv_write_busy};
            end
            default: begin
               rd_op_r <= 1'b0;
            end
         endcase
      end else if (sck_fall && state_r == SWD_DATA) begin
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end

   // (RQ18) output moves only on falling serial clock
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         so_out <= 1'b0;
         so_oe_n <= 1'b1;
      end else begin
         so_oe_n <= !(state_r == SWD_DATA && rd_op_r && !p.cs_n);
         if (sck_fall && state_r == SWD_DATA && rd_op_r) begin
            so_out <= tx_r[7];
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   chk_id_reject: assert property (byte_done && state_r == SWD_ID && !cs_rise && !id_ok // (RQ2)
      |=> state_r == SWD_IGNORE)
      else $error("foreign identification accepted");
   chk_step_up: assert property (state_r == SWD_INCDEC && sck_rise && p.si // (RQ16)
      && wiper_position_reg_r != `SWD_WIPER_MAX
      |=> wiper_position_reg_r == $past(wiper_position_reg_r) + 6'h01)
      else $error("step up missed");
   chk_step_down: assert property (state_r == SWD_INCDEC && sck_rise && !p.si // (RQ17)
      && wiper_position_reg_r != `SWD_WIPER_MIN
      |=> wiper_position_reg_r == $past(wiper_position_reg_r) - 6'h01)
      else $error("step down missed");
   chk_step_clamp: assert property (state_r == SWD_INCDEC && sck_rise && p.si // (RQ22)
      && wiper_position_reg_r == `SWD_WIPER_MAX |=> wiper_position_reg_r == `SWD_WIPER_MAX)
      else $error("wiper wrapped past top");
   chk_xfr_load: assert property (instr_done && !cs_rise // (RQ8)
      && op_nxt == `SWD_OP_SET_TO_WIPER
      |=> wiper_position_reg_r == $past(stored_setting_reg_r[ptr_nxt]))
      else $error("transfer to wiper wrong");
   chk_wiper_write: assert property (data_done && !cs_rise // (RQ12)
      && op_r == `SWD_OP_WR_WIPER
      |=> wiper_position_reg_r == $past(rx_nxt[5:0]))
      else $error("wiper write wrong");
   chk_so_edge: assert property ($changed(so_out) |-> $past(sck_fall)) // (RQ18)
      else $error("serial output moved off a falling edge");
   chk_save_start: assert property (nv_start |=> nv_write_busy ##1 nv_write_busy) // (RQ19)
      else $error("save did not raise busy");
   chk_protect: assert property (cs_rise && frame_ok_r && !p.wp_n && !nv_write_busy
      |=> !nv_write_busy) // (RQ20)
      else $error("protected save started");
   // The register must have held the new value a settle time (ten cycles) before and one cycle before
   chk_settle: assert property ($changed(wiper_bits) // (RQ8)
      |-> wiper_bits == $past(wiper_position_reg_r, 10)
      && wiper_bits == $past(wiper_position_reg_r))
      else $error("wiper output followed too early");

   cov_step: cover property (state_r == SWD_INCDEC && sck_rise);
   cov_status: cover property (instr_done && op_nxt == `SWD_OP_STATUS);
   cov_save: cover property (nv_start);
   cov_reject: cover property (byte_done && state_r == SWD_ID && !id_ok);

endmodule // swd_top

// *** sim/swd_host_model.sv ***
// Host serial master model: frames of up to 32 bits, MSB first.
// Assumes a free-running core clock; sck idles low and stops between frames.
module swd_host_model
   import swd_pkg::*;
(
   input wire logic core_clk,
   input wire logic so_out,
   input wire logic so_oe_n,
   output logic cs_n,
   output logic sck,
   output logic si
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // Frame driver
   // ------------------------------------------------------------
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // shift out bits
   // Data moves only while sck is low; phases of 4 clocks give a 320 ns link clock
   task automatic xfer(input logic [31:0] tx, input int n, output logic [7:0] rx);
      int i;
      rx = 8'h00;
      cs_n <= 1'b0;
      hold(8);
      for (i = 0; i < n; i++) begin
         si <= tx[31-i];
         hold(4);
         sck <= 1'b1;
         hold(4);
         // Output lags a fall by about five clocks, so take it at the end of the high phase
         // An undriven line reads as unknown, so a missing enable never matches
         rx = {rx[6:0], so_oe_n ? 1'bx : so_out};
         sck <= 1'b0;
      end
      hold(8);
      cs_n <= 1'b1;
      si <= ~si;
      hold(16);
   endtask
endmodule // swd_host_model

// *** sim/swd_top_tb.sv ***
// Bench of the serial wiper decoder: host model plus sequenced frames.
// Assumes swd_params.svh on the include path; save time shortened to 500.
`include "swd_params.svh"
module swd_top_tb
   import swd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // Set-up
   // ------------------------------------------------------------
   localparam int NVC = 500;
   localparam logic [7:0] ID = 8'had;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic asel = 1'b1;
   logic wp_n = 1'b1;
   logic cs_n, sck, si, so_out, so_oe_n, busy;
   logic [5:0] wiper_bits;
   logic [7:0] rx;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;

   always #20 core_clk = ~core_clk;

   swd_top #(.NV_WRITE_CYCLES(NVC)) i_dut (
      .core_clk(core_clk),
      .rst(rst),
      .cs_n_pin(cs_n),
      .sck_pin(sck),
      .si_pin(si),
      .address_select_pin(asel),
      .wp_n_pin(wp_n),
      .so_out(so_out),
      .so_oe_n(so_oe_n),
      .wiper_bits(wiper_bits),
      .nv_write_busy(busy)
   );

   swd_host_model i_host (
      .core_clk(core_clk),
      .so_out(so_out),
      .so_oe_n(so_oe_n),
      .cs_n(cs_n),
      .sck(sck),
      .si(si)
   );

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic frame(input logic [31:0] tx, input int n);
      i_host.xfer(tx, n, rx);
   endtask

   task automatic wait_idle;
      int k;
      for (k = 0; k < NVC + 100 && busy !== 1'b0; k++) begin
         @(posedge core_clk);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Hang guard, well above the few thousand cycles the sequence needs
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      int k;
      logic [7:0] bad [2];
      bad[0] = ID ^ 8'h01;
      bad[1] = ID ^ 8'h80;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      repeat (8) @(posedge core_clk);
      frame({ID, `SWD_OP_WR_WIPER, 4'h0, 8'hea, 8'h00}, 24);
      check({2'b00, wiper_bits}, 8'h2a);
      frame({ID, `SWD_OP_RD_WIPER, 4'h0, 16'h0000}, 24);
      check(rx, 8'h2a);
      frame({ID, `SWD_OP_WR_SET, 4'h8, 8'h15, 8'h00}, 24);
      check({7'h00, busy}, 8'h01);
      frame({ID, `SWD_OP_STATUS, 2'b00, `SWD_STATUS_LOW, 16'h0000}, 24);
      check(rx, 8'h01);
      wait_idle();
      check({7'h00, busy}, 8'h00);
      frame({ID, `SWD_OP_STATUS, 2'b00, `SWD_STATUS_LOW, 16'h0000}, 24);
      check(rx, 8'h00);
      frame({ID, `SWD_OP_RD_SET, 4'h8, 16'h0000}, 24);
      check(rx, 8'h15);
      frame({ID, `SWD_OP_RD_SET, 4'h4, 16'h0000}, 24);
      check(rx, 8'h00);
      frame({ID, `SWD_OP_SET_TO_WIPER, 4'h8, 16'h0000}, 16);
      check({2'b00, wiper_bits}, 8'h15);
      frame({ID, `SWD_OP_WR_WIPER, 4'h0, 8'h3e, 8'h00}, 24);
      frame({ID, `SWD_OP_INCDEC, 4'h0, 16'he000}, 19);
      check({2'b00, wiper_bits}, 8'h3f);
      frame({ID, `SWD_OP_INCDEC, 4'h0, 16'h0000}, 18);
      check({2'b00, wiper_bits}, 8'h3d);
      wp_n <= 1'b0;
      frame({ID, `SWD_OP_WIPER_TO_SET, 4'hc, 16'h0000}, 16);
      check({7'h00, busy}, 8'h00);
      frame({ID, `SWD_OP_WR_WIPER, 4'h0, 8'h3c, 8'h00}, 24);
      check({2'b00, wiper_bits}, 8'h3c);
      wp_n <= 1'b1;
      frame({ID, `SWD_OP_RD_SET, 4'hc, 16'h0000}, 24);
      check(rx, 8'h00);
      frame({ID, `SWD_OP_WIPER_TO_SET, 4'hc, 16'h0000}, 16);
      check({7'h00, busy}, 8'h01);
      wait_idle();
      frame({ID, `SWD_OP_RD_SET, 4'hc, 16'h0000}, 24);
      check(rx, 8'h3c);
      for (k = 0; k < 2; k++) begin
         frame({bad[k], `SWD_OP_WR_WIPER, 4'h0, 8'h01, 8'h00}, 24);
         check({2'b00, wiper_bits}, 8'h3c);
      end
      complete_run();
   end
endmodule // swd_top_tb
